// [lsf_pkg.sv]
package lsf_pkg;
  // Register indices on the plain port
  localparam logic [3:0] LSF_REG_CTRL   = 4'h0;
  localparam logic [3:0] LSF_REG_SLEN   = 4'h1;
  localparam logic [3:0] LSF_REG_RANGE  = 4'h2;
  localparam logic [3:0] LSF_REG_REC    = 4'h3;
  localparam logic [3:0] LSF_REG_STAT   = 4'h4;
  localparam logic [3:0] LSF_REG_CRC    = 4'h5;
  // Control field positions
  localparam int CTL_CMD_LSB = 0;
  localparam int CTL_WIDE    = 3;
  localparam int CTL_GLITCH  = 4;
  localparam int CTL_BINARY  = 5;
  localparam int CTL_LARGE   = 6;
  localparam int CTL_OVW     = 7;
  localparam logic [15:0] CTL_RESET = 16'h0020;
  // Start commands in the control word
  localparam logic [2:0] CMD_STATE  = 3'h1;
  localparam logic [2:0] CMD_TIMING = 3'h2;
  localparam logic [2:0] CMD_CONFIG = 3'h3;
  localparam logic [2:0] CMD_ALL    = 3'h4;
  // Two-character headers
  localparam logic [15:0] RECEIVE_STATE_HEADER         = 16'h5253;
  localparam logic [15:0] RECEIVE_TIMING_HEADER        = 16'h5254;
  localparam logic [15:0] RECEIVE_CONFIGURATION_HEADER = 16'h5243;
  // String positions (first header byte is position 1)
  localparam logic [12:0] POS_BODY      = 13'h0005;
  localparam logic [12:0] POS_OVW_TYPE  = 13'h000C;
  localparam logic [12:0] POS_TIM_CHAN  = 13'h0005;
  localparam logic [12:0] POS_TIM_VAL0  = 13'h0006;
  localparam logic [12:0] POS_TIM_VAL1  = 13'h0007;
  localparam logic [12:0] POS_TIM_GLT   = 13'h000A;
  localparam logic [12:0] POS_TIM_REC   = 13'h0014;
  localparam logic [12:0] POS_LSTATE    = 13'h001B;
  // Inserted codes and fixed sizes
  localparam logic [7:0]  OVW_TYPE_CODE = 8'h02;
  localparam logic [7:0]  CHAN_NARROW   = 8'h08;
  localparam logic [7:0]  CHAN_WIDE     = 8'h10;
  localparam logic [12:0] OVW_FIXED_CNT = 13'h002A;
  localparam logic [12:0] OVW_RANGE_LEN = 13'h000E;
  localparam logic [12:0] TIM_FIXED_CNT = 13'h0011;
  localparam logic [12:0] CRC_LEN       = 13'h0002;
  localparam logic [3:0]  OVW_RANGES    = 4'h8;
  localparam logic [7:0]  CHAR_CR       = 8'h0D;
  localparam logic [7:0]  CHAR_LF       = 8'h0A;
  // CRC-16 choice used for both ends
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  // Frame kinds and sequencer states
  typedef enum logic [1:0] {K_STATE, K_OVW, K_TIMING, K_CONFIG} lsf_kind_t;
  typedef enum logic [3:0] {S_IDLE, S_HDR0, S_HDR1, S_CNT0, S_CNT1,
                            S_BODY, S_CRC0, S_CRC1, S_CR, S_LF} lsf_fsm_t;
endpackage

// [lsf_crc.sv]
`timescale 1ns/10ps
`default_nettype none
module lsf_crc (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic [15:0]      crc
);
  import lsf_pkg::*;
  typedef struct packed {logic [15:0] crc;} lsf_crc_t;
  lsf_crc_t q;        // Running remainder
  lsf_crc_t n;        // Next remainder
  logic [15:0] c;     // Bitwise work value

  // One byte per enable, MSB first
  always_comb begin
    c = q.crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    n = q;
    if (clear) begin
      n.crc = CRC_INIT;
    end else if (en) begin
      n.crc = c;
    end
  end

  // Remainder register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{crc: CRC_INIT};
    end else begin
      q <= n;
    end
  end

  assign crc = q.crc;
endmodule
`default_nettype wire

// [lsf_framer.sv]
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module lsf_framer #(
  parameter int         REC_MAX   = 1024,     // Records in a full memory
  parameter int         CFG_COUNT = 5476,     // Configuration byte count
  parameter logic [7:0] REV_CODE  = 8'h00     // Revision code, arbitrary
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata,
  input  wire logic [15:0]      src_data,
  input  wire logic             src_valid,
  output logic                  src_ready,
  output logic [7:0]            bus_data,
  output logic                  bus_valid,
  input  wire logic             bus_ready,
  output logic                  bus_eoi
);
  import lsf_pkg::*;

  // Refuse sizes that the 13-bit counts cannot hold
  if (REC_MAX < 1 || REC_MAX > 4000) begin : g_bad_rec
    $error("REC_MAX out of range");
  end
  if (CFG_COUNT < 4 || CFG_COUNT > 8000) begin : g_bad_cfg
    $error("CFG_COUNT out of range");
  end

  // Whole module state
  typedef struct packed {
    lsf_fsm_t    fsm;      // Sequencer
    lsf_kind_t   kind;     // Frame being sent
    logic        all;      // Inside a transmit-everything run
    logic [12:0] pos;      // Position of next body byte
    logic [12:0] count;    // Byte count of current frame
    logic [7:0]  out;      // Byte on the bus
    logic        vld;      // Bus byte valid
    logic        eoi;      // End marker beside the byte
    logic        rdy;      // Source may hand a word
    logic        pend;     // Low byte of a wide record waiting
    logic [7:0]  lo;       // That low byte
    logic [3:0]  phase;    // Byte within a large state
    logic [15:0] ctrl;     // Control word
    logic [12:0] slen;     // State payload length
    logic [3:0]  ranges;   // Overview ranges in use
    logic [3:0]  stride;   // Bytes per large state
    logic [11:0] recs;     // Timing records held
    logic [7:0]  frames;   // Frames finished
    logic [15:0] rdata;    // Read answer
  } lsf_st_t;

  lsf_st_t     q;          // Registered state
  lsf_st_t     n;          // Next state
  logic [15:0] crc;        // Running CRC
  logic        crc_clr;    // Restart CRC at header
  logic        crc_en;     // Body byte leaves
  logic        can_load;   // Output slot free
  logic [7:0]  byte_v;     // Candidate body byte
  logic        need_src;   // Body byte comes from source
  logic        word_rec;   // Wide record word
  logic        last_frm;   // Last string of the transfer
  logic [12:0] last_body;  // Position of the last body byte
  logic [15:0] hdr_w;      // Header of the frame being sent

  // Byte count of a frame kind
  function automatic logic [12:0] count_of(lsf_kind_t k, lsf_st_t s);
    logic [12:0] r;
    r = 13'h0000;
    unique case (k)
      K_STATE:  r = s.slen + CRC_LEN;
      K_OVW:    r = OVW_FIXED_CNT + OVW_RANGE_LEN * {9'h000, s.ranges};
      K_TIMING: r = TIM_FIXED_CNT + (s.ctrl[CTL_WIDE] ? {s.recs, 1'b0}
                                                      : {1'b0, s.recs});
      K_CONFIG: r = 13'(CFG_COUNT);
    endcase
    return r;
  endfunction

  // Header of a frame kind
  function automatic logic [15:0] hdr_of(lsf_kind_t k);
    logic [15:0] h;
    h = RECEIVE_STATE_HEADER;
    if (k == K_TIMING) h = RECEIVE_TIMING_HEADER;
    if (k == K_CONFIG) h = RECEIVE_CONFIGURATION_HEADER;
    return h;
  endfunction

  // A function result cannot be part-selected, so it is held in a net
  assign hdr_w = hdr_of(q.kind);

  lsf_crc u_crc (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (crc_clr),
    .en    (crc_en),
    .data  (byte_v),
    .crc   (crc)
  );

  // Body byte selection; fields the block owns are inserted, rest streamed
  always_comb begin
    byte_v   = src_data[7:0];
    need_src = 1'b1;
    word_rec = 1'b0;
    unique case (q.kind)
      K_OVW: begin
        if (q.pos == POS_OVW_TYPE) begin
          byte_v   = OVW_TYPE_CODE;
          need_src = 1'b0;
        end
      end
      K_TIMING: begin
        if (q.pos == POS_TIM_CHAN) begin
          byte_v   = q.ctrl[CTL_WIDE] ? CHAN_WIDE : CHAN_NARROW;
          need_src = 1'b0;
        end else if (q.pos == POS_TIM_VAL0) begin
          byte_v   = {4'h0, q.recs[11:8]};
          need_src = 1'b0;
        end else if (q.pos == POS_TIM_VAL1) begin
          byte_v   = q.recs[7:0];
          need_src = 1'b0;
        end else if (q.pos == POS_TIM_GLT) begin
          byte_v   = {7'h00, q.ctrl[CTL_GLITCH]};
          need_src = 1'b0;
        end else if (q.pos >= POS_TIM_REC && q.ctrl[CTL_WIDE]) begin
          // Wide records: upper pod first, lower pod held for next byte
          word_rec = !q.pend;
          byte_v   = q.pend ? q.lo : src_data[15:8];
          need_src = !q.pend;
        end
      end
      K_CONFIG: begin
        if (q.pos == last_body) begin
          byte_v   = REV_CODE;
          need_src = 1'b0;
        end
      end
      K_STATE: begin
        if (q.ctrl[CTL_LARGE] && q.pos >= POS_LSTATE && q.phase == 4'h0) begin
          byte_v = {6'h00, src_data[1:0]};
        end
      end
    endcase
  end

  assign can_load  = !q.vld || bus_ready;
  assign last_body = q.count + CRC_LEN;
  assign last_frm  = !q.all || q.kind == K_TIMING;

  // Sequencer, register port and stream handshake
  always_comb begin
    n       = q;
    crc_clr = 1'b0;
    crc_en  = 1'b0;
    if (bus_ready) begin
      n.vld = 1'b0;
      n.eoi = 1'b0;
    end
    n.rdata = 16'h0000;
    // Register reads answer one cycle later; unmapped reads give zero
    if (reg_rd) begin
      unique case (reg_addr)
        LSF_REG_CTRL:  n.rdata = q.ctrl;
        LSF_REG_SLEN:  n.rdata = {3'h0, q.slen};
        LSF_REG_RANGE: n.rdata = {8'h00, q.stride, q.ranges};
        LSF_REG_REC:   n.rdata = {4'h0, q.recs};
        LSF_REG_STAT:  n.rdata = {q.fsm != S_IDLE, 7'h00, q.frames};
        LSF_REG_CRC:   n.rdata = crc;
        default:       n.rdata = 16'h0000;
      endcase
    end
    // Settings change only while idle, so a frame keeps its shape
    if (reg_wr && q.fsm == S_IDLE) begin
      unique case (reg_addr)
        LSF_REG_CTRL: begin
          n.ctrl = {reg_wdata[15:3], 3'h0};
          if (reg_wdata[2:0] != 3'h0) begin
            n.fsm  = S_HDR0;
            n.all  = reg_wdata[2:0] == CMD_ALL;
            n.kind = K_STATE;
            if (reg_wdata[2:0] == CMD_STATE && reg_wdata[CTL_OVW]) n.kind = K_OVW;
            if (reg_wdata[2:0] == CMD_TIMING) n.kind = K_TIMING;
            if (reg_wdata[2:0] == CMD_CONFIG || reg_wdata[2:0] == CMD_ALL) begin
              n.kind = K_CONFIG;
            end
          end
        end
        LSF_REG_SLEN:  n.slen = reg_wdata[12:0];
        LSF_REG_RANGE: begin
          n.ranges = (reg_wdata[3:0] > OVW_RANGES) ? OVW_RANGES : reg_wdata[3:0];
          n.stride = reg_wdata[7:4];
        end
        LSF_REG_REC:   begin
          n.recs = (reg_wdata[11:0] > 12'(REC_MAX)) ? 12'(REC_MAX) : reg_wdata[11:0];
        end
        default: ;
      endcase
    end
    n.rdy = 1'b0;
    if (can_load) begin
      unique case (q.fsm)
        S_IDLE: ;
        S_HDR0: begin
          crc_clr = 1'b1;
          n.count = count_of(q.kind, q);
          n.out   = hdr_w[15:8];
          n.vld   = 1'b1;
          n.fsm   = S_HDR1;
        end
        S_HDR1: begin
          n.out = hdr_w[7:0];
          n.vld = 1'b1;
          n.fsm = S_CNT0;
        end
        S_CNT0: begin
          n.out = {3'h0, q.count[12:8]};
          n.vld = 1'b1;
          n.fsm = S_CNT1;
        end
        S_CNT1: begin
          n.out   = q.count[7:0];
          n.vld   = 1'b1;
          n.pos   = POS_BODY;
          n.phase = 4'h0;
          n.pend  = 1'b0;
          n.fsm   = (q.count == CRC_LEN) ? S_CRC0 : S_BODY;
        end
        S_BODY: begin
          if (!need_src || (src_valid && q.rdy)) begin
            crc_en = q.kind != K_CONFIG || q.pos != last_body;
            n.out  = byte_v;
            n.vld  = 1'b1;
            n.pos  = q.pos + 13'h0001;
            n.pend = word_rec;
            if (word_rec) n.lo = src_data[7:0];
            if (q.pos >= POS_LSTATE) begin
              n.phase = (q.phase + 4'h1 >= q.stride) ? 4'h0 : q.phase + 4'h1;
            end
            if (q.pos == last_body) n.fsm = S_CRC0;
          end else begin
            n.rdy = 1'b1;
          end
        end
        S_CRC0: begin
          n.out = crc[15:8];
          n.vld = 1'b1;
          n.fsm = S_CRC1;
        end
        S_CRC1: begin
          n.out    = crc[7:0];
          n.vld    = 1'b1;
          n.frames = q.frames + 8'h01;
          n.eoi    = last_frm && q.ctrl[CTL_BINARY];
          if (!last_frm) begin
            n.fsm  = S_HDR0;
            n.kind = (q.kind == K_CONFIG) ? (q.ctrl[CTL_OVW] ? K_OVW : K_STATE)
                                          : K_TIMING;
          end else begin
            n.fsm = q.ctrl[CTL_BINARY] ? S_IDLE : S_CR;
          end
        end
        S_CR: begin
          n.out = CHAR_CR;
          n.vld = 1'b1;
          n.fsm = S_LF;
        end
        S_LF: begin
          n.out = CHAR_LF;
          n.vld = 1'b1;
          n.eoi = 1'b1;
          n.fsm = S_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{fsm: S_IDLE, kind: K_STATE, ctrl: CTL_RESET, default: '0};
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign src_ready = q.rdy;
  assign bus_data  = q.out;
  assign bus_valid = q.vld;
  assign bus_eoi   = q.eoi;

  // Checks on the byte stream
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hdr_sent;
    q.fsm == S_HDR0 && can_load;
  endsequence
  sequence cnt_msb_sent;
    q.fsm == S_CNT0 && can_load;
  endsequence

  a_out_hold: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_data))
    else $error("Bus byte changed while not taken");
  a_hdr_first: assert property (hdr_sent |=> bus_valid && bus_data == hdr_w[15:8])
    else $error("Header byte wrong");
  a_cnt_order: assert property (cnt_msb_sent |=> bus_data == {3'h0, q.count[12:8]})
    else $error("Count MSB not first");
  a_ovw_code: assert property (q.fsm == S_BODY && q.kind == K_OVW && q.pos == POS_OVW_TYPE
    && can_load |=> bus_data == OVW_TYPE_CODE) else $error("Type code not 2");
  a_ovw_limit: assert property (q.kind == K_OVW && q.fsm == S_BODY |-> q.count <= 13'h09A)
    else $error("Overview count above 154");
  a_tim_limit: assert property (q.kind == K_TIMING && q.fsm == S_BODY
    |-> q.count <= 13'h811) else $error("Timing count above 2065");
  a_glitch_flag: assert property (q.fsm == S_BODY && q.kind == K_TIMING
    && q.pos == POS_TIM_GLT && can_load |=> bus_data == {7'h00, q.ctrl[CTL_GLITCH]})
    else $error("Glitch flag wrong");
  a_eoi_byte: assert property (bus_eoi |-> bus_valid)
    else $error("EOI without a byte");
  a_lf_eoi: assert property (q.fsm == S_CR && can_load ##1 bus_ready |=> bus_data == CHAR_LF
    && bus_eoi) else $error("LF without EOI");
  a_crc_frozen: assert property (q.fsm == S_CRC0 |=> $stable(crc))
    else $error("CRC moved over its own bytes");
  a_large_msb: assert property (q.fsm == S_BODY && q.kind == K_STATE && q.ctrl[CTL_LARGE]
    && q.pos >= POS_LSTATE && q.phase == 4'h0 && src_valid && q.rdy |=> bus_data[7:2] == 6'h00)
    else $error("Internal bits not cleared");
endmodule
`default_nettype wire

// [lsf_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Bus controller taking learn strings, plus the measurement source
module lsf_bus_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic [7:0]  bus_data,
  input  wire logic        bus_valid,
  output logic             bus_ready,
  input  wire logic        bus_eoi,
  output logic [15:0]      src_data,
  output logic             src_valid,
  input  wire logic        src_ready
);
  logic [7:0]  got [0:16383];   // Every byte taken off the bus
  logic        eoi [0:16383];   // End flag seen with each byte
  logic [15:0] srcw [0:16383];  // Every source word handed over
  int          n_got;           // Bytes taken so far
  int          n_src;           // Source words taken so far
  logic [7:0]  seq;             // Source pattern counter
  logic        ph;              // Alternating phase for slow replies

  // Upper byte differs from lower so a swapped pod order shows
  function automatic logic [15:0] word_of(input logic [7:0] s);
    return {s ^ 8'hA5, s};
  endfunction

  // Bus side takes bytes; source side holds each word until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph        <= 1'b0;
      bus_ready <= 1'b0;
      src_valid <= 1'b0;
      src_data  <= 16'h0000;
      seq       <= 8'h00;
      n_got     <= 0;
      n_src     <= 0;
    end else begin
      ph        <= ~ph;
      // Slow controller takes a byte every other cycle only
      bus_ready <= stall ? ph : 1'b1;
      if (bus_valid && bus_ready) begin
        got[n_got] <= bus_data;
        eoi[n_got] <= bus_eoi;
        n_got      <= n_got + 1;
      end
      if (src_valid && src_ready) begin
        srcw[n_src] <= src_data;
        n_src       <= n_src + 1;
        seq         <= seq + 8'h01;
        src_valid   <= !stall;
        src_data    <= stall ? ~word_of(seq) : word_of(seq + 8'h01);
      end else if (!src_valid) begin
        // Idle slow source shows the fixed junk word 16'h00A5 in its off phase
        src_valid <= !stall || ph;
        src_data  <= (!stall || ph) ? word_of(seq) : {8'h00, ph ? 8'h5A : 8'hA5};
      end
    end
  end
endmodule
`default_nettype wire

// [learn_string_framer_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module learn_string_framer_tb_top;
  import lsf_pkg::*;
  logic        clk;       // 50 MHz clock
  logic        rst_n;     // Active low reset
  logic [3:0]  reg_addr;  // Register index
  logic [15:0] reg_wdata; // Register write data
  logic        reg_wr;    // Write strobe
  logic        reg_rd;    // Read strobe
  logic [15:0] reg_rdata; // Read answer
  logic [15:0] src_data;  // Source word
  logic        src_valid; // Source word present
  logic        src_ready; // Framer takes source word
  logic [7:0]  bus_data;  // Byte on the bus
  logic        bus_valid; // Byte present
  logic        bus_ready; // Controller takes byte
  logic        bus_eoi;   // End of transfer flag
  logic        stall;     // Slow far side
  int          n_mismatch;
  int          checks_done;
  int          b;         // First byte of the transfer under test
  int          s0;        // First source word of the transfer
  logic [15:0] rd;        // Last register read

  lsf_framer dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .bus_data(bus_data),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_eoi(bus_eoi));
  lsf_bus_model m (.clk(clk), .rst_n(rst_n), .stall(stall), .bus_data(bus_data),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_eoi(bus_eoi),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready));

  // Free running clock
  always #10 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // CRC-16 worked out independently over captured bytes
  function automatic logic [15:0] crc_of(input int f, input int l);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = f; i <= l; i++) begin
      c = c ^ {m.got[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Start a transfer and wait for all of its bytes, then for silence
  task automatic run(input logic [15:0] ctrl, input int total);
    int n;
    b  = m.n_got;
    s0 = m.n_src;
    reg_write(LSF_REG_CTRL, ctrl);
    n = 0;
    while (m.n_got < b + total && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check(16'(m.n_got - b), 16'(total));
  endtask

  // Header, count and CRC of one frame; returns the next frame start
  task automatic frame(input int f, input logic [15:0] hdr, input int cnt, input bit rev,
                       output int nxt);
    check({m.got[f], m.got[f+1]}, hdr);
    check({m.got[f+2], m.got[f+3]}, 16'(cnt));
    check({m.got[f+cnt+2], m.got[f+cnt+3]}, crc_of(f + 4, f + cnt + 1 - rev));
    nxt = f + 4 + cnt;
  endtask

  // End marking of the whole transfer
  task automatic fin(input int last, input bit text);
    int e;
    e = 0;
    for (int i = b; i <= last; i++) e += m.eoi[i];
    check(16'(e), 16'h0001);
    check({15'h0000, m.eoi[last]}, 16'h0001);
    if (text) check({m.got[last-1], m.got[last]}, {CHAR_CR, CHAR_LF});
  endtask

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    int nx;
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    reg_read(LSF_REG_CTRL, rd);
    check(rd, CTL_RESET);
    reg_read(LSF_REG_STAT, rd);
    check(rd, 16'h0000);
    reg_read(4'hF, rd);
    check(rd, 16'h0000);
    // Partial narrow timing with glitch mode, slow far side
    reg_write(LSF_REG_REC, 16'h0003);
    run(16'h0032, 24);
    frame(b, RECEIVE_TIMING_HEADER, 20, 1'b0, nx);
    check({8'h00, m.got[b+4]}, {8'h00, CHAN_NARROW});
    check({m.got[b+5], m.got[b+6]}, 16'h0003);
    check({15'h0000, m.got[b+9] != 8'h00}, 16'h0001);
    check({8'h00, m.got[b+19]}, {8'h00, m.srcw[s0+11][7:0]});
    fin(b + 23, 1'b0);
    // Full wide memory as text, prompt far side
    stall <= 1'b0;
    reg_write(LSF_REG_REC, 16'h0FFF);
    run(16'h000A, 2071);
    frame(b, RECEIVE_TIMING_HEADER, 2065, 1'b0, nx);
    check({8'h00, m.got[b+4]}, {8'h00, CHAN_WIDE});
    check({8'h00, m.got[b+9]}, 16'h0000);
    check({m.got[b+19], m.got[b+20]}, m.srcw[s0+11]);
    fin(b + 2070, 1'b1);
    // Overview with too many ranges asked for
    stall <= 1'b1;
    reg_write(LSF_REG_RANGE, 16'h0009);
    run(16'h00A1, 158);
    frame(b, RECEIVE_STATE_HEADER, 154, 1'b0, nx);
    check({8'h00, m.got[b+11]}, {8'h00, OVW_TYPE_CODE});
    check({8'h00, m.got[b+10]}, {8'h00, m.srcw[s0+6][7:0]});
    check({8'h00, m.got[b+12]}, {8'h00, m.srcw[s0+7][7:0]});
    fin(b + 157, 1'b0);
    // Large model state frame, four bytes a state from position 27
    reg_write(LSF_REG_RANGE, 16'h0040);
    reg_write(LSF_REG_SLEN, 16'h001E);
    run(16'h0061, 36);
    frame(b, RECEIVE_STATE_HEADER, 32, 1'b0, nx);
    check({8'h00, m.got[b+26]}, {14'h0000, m.srcw[s0+22][1:0]});
    check({8'h00, m.got[b+27]}, {8'h00, m.srcw[s0+23][7:0]});
    check({8'h00, m.got[b+30]}, {14'h0000, m.srcw[s0+26][1:0]});
    fin(b + 35, 1'b0);
    // Everything: configuration, state, timing; writes refused while busy
    stall <= 1'b0;
    reg_write(LSF_REG_SLEN, 16'h0005);
    reg_write(LSF_REG_REC, 16'h0003);
    fork
      run(16'h0024, 5515);
      begin
        repeat (40) @(posedge clk);
        reg_write(LSF_REG_SLEN, 16'h01FF);
        reg_read(LSF_REG_STAT, rd);
        check({15'h0000, rd[15]}, 16'h0001);
      end
    join
    reg_read(LSF_REG_SLEN, rd);
    check(rd, 16'h0005);
    frame(b, RECEIVE_CONFIGURATION_HEADER, 5476, 1'b1, nx);
    check({8'h00, m.got[b+5477]}, 16'h0000);
    frame(nx, RECEIVE_STATE_HEADER, 7, 1'b0, nx);
    frame(nx, RECEIVE_TIMING_HEADER, 20, 1'b0, nx);
    fin(b + 5514, 1'b0);
    // Configuration alone as text
    run(16'h0003, 5482);
    frame(b, RECEIVE_CONFIGURATION_HEADER, 5476, 1'b1, nx);
    check({8'h00, m.got[b+5477]}, 16'h0000);
    fin(b + 5481, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
